// File: verilog/sbi_pkg.sv
`default_nettype none
package sbi_pkg;
  // Address decode
  localparam logic [3:0] ADDR_HI_FIXED = 4'hc;
  localparam logic [7:0] ADDR_LO_PG = 8'h00;
  localparam logic [7:0] ADDR_LO_QC = 8'h01;
  // Control register fields
  localparam int CTL_PG_RST_PULSE = 0;
  localparam int CTL_PG_RUN = 1;
  localparam int CTL_QC_RST_PULSE = 2;
  localparam int CTL_SEL_LO = 3;
  localparam int CTL_LED = 5;
  localparam int CTL_DRV_EN = 6;
  localparam int CTL_TWO_PHASE = 7;
  localparam logic [7:0] CTRL_RESET = 8'h80;
  // Command byte layout
  localparam int CMD_GRP_LO = 6;
  localparam logic [1:0] GRP_CTRL = 2'h0;
  localparam logic [1:0] GRP_MODE = 2'h1;
  localparam logic [1:0] GRP_STOP = 2'h2;
  localparam int CMD_START = 0;
  localparam int CMD_HIGH = 4;
  localparam int MODE_STOPS_EN = 1;
  localparam int MODE_ORIGIN = 2;
  localparam int MODE_NEG = 3;
  localparam int STOP_SOFT_RST = 0;
  localparam int STOP_DECEL = 1;
  // Status byte layout
  localparam int ST_EL_NEG = 0;
  localparam int ST_EL_POS = 1;
  localparam int ST_ORG = 2;
  localparam int ST_BUSY = 6;
  localparam int ST_IRQ = 7;
  // Timing
  localparam int CLK_HZ = 250_000_000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int RST_PULSE_NS = 100;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WD_TIMEOUT_US = 100_000;
  localparam int WD_CYC_DEFAULT = WD_TIMEOUT_US / CLK_PERIOD_NS * 1000;
  // Pulse rate scaling
  localparam int RATE_W = 13;
  localparam int MULT_W = 16;
  localparam int ACC_W = 40;
  localparam int MULT_PPS = 732;
  localparam real PPS_SCALE = 1.000576331967;
  localparam logic [ACC_W-1:0] PPS_MOD = ACC_W'(longint'(real'(CLK_HZ) * real'(MULT_PPS) / PPS_SCALE));
endpackage
`default_nettype wire

// File: verilog/sbi_pulse_gen.sv
`timescale 1ns/1ps
`default_nettype none
module sbi_pulse_gen
  import sbi_pkg::*;
#(
  parameter int RW = RATE_W,
  parameter int MW = MULT_W
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hard_rst,
  // Command port
  input wire logic cmd_stb,
  input wire logic [7:0] cmd_data,
  // Rates and inputs
  input wire logic [RW-1:0] low_speed_rate,
  input wire logic [RW-1:0] high_speed_rate,
  input wire logic [MW-1:0] rate_multiplier,
  input wire logic limit_neg_n,
  input wire logic limit_pos_n,
  input wire logic origin_n,
  // Results
  output logic [7:0] status,
  output logic step_pulse,
  output logic step_dir,
  output logic irq
);
  if (RW + MW >= ACC_W)
    $error("sbi_pulse_gen: rate and multiplier too wide");

  typedef struct packed {
    logic running;
    logic neg;
    logic origin_mode;
    logic stops_en;
    logic high;
    logic irq;
    logic el_neg;
    logic el_pos;
    logic org;
    logic pulse;
    logic [ACC_W-1:0] acc;
  } sbi_pg_t;

  sbi_pg_t r_reg, r_next;
  logic [ACC_W-1:0] inc;
  logic [ACC_W-1:0] sum;
  logic hit;

  // Next state; a stop hit sets irq after a soft reset clears it
  always_comb
  begin
    r_next = r_reg;
    r_next.pulse = 1'b0;
    inc = ACC_W'(r_reg.high ? high_speed_rate : low_speed_rate) * ACC_W'(rate_multiplier);
    sum = r_reg.acc + inc;
    hit = 1'b0;
    r_next.el_neg = ~limit_neg_n;
    r_next.el_pos = ~limit_pos_n;
    r_next.org = ~origin_n;
    if (r_reg.running)
    begin
      // Rate accumulator: one pulse per PPS_MOD of rate times multiplier
      if (sum >= PPS_MOD)
      begin
        r_next.acc = sum - PPS_MOD;
        r_next.pulse = 1'b1;
      end
      else
        r_next.acc = sum;
      hit = (r_reg.stops_en && (r_reg.neg ? r_reg.el_neg : r_reg.el_pos))
        || ((r_reg.stops_en || r_reg.origin_mode) && r_reg.org);
    end
    if (cmd_stb)
    begin
      unique case (cmd_data[CMD_GRP_LO +: 2])
        GRP_MODE:
        begin
          r_next.neg = cmd_data[MODE_NEG];
          r_next.origin_mode = cmd_data[MODE_ORIGIN];
          r_next.stops_en = cmd_data[MODE_STOPS_EN];
        end
        GRP_CTRL:
          if (cmd_data[CMD_START])
          begin
            r_next.running = 1'b1;
            r_next.high = cmd_data[CMD_HIGH];
            r_next.acc = '0;
          end
        GRP_STOP:
        begin
          if (cmd_data[STOP_SOFT_RST])
          begin
            r_next.running = 1'b0;
            r_next.irq = 1'b0;
          end
          if (cmd_data[STOP_DECEL])
            r_next.running = 1'b0;
        end
        default:
          r_next = r_next;
      endcase
    end
    if (hit)
    begin
      r_next.running = 1'b0;
      r_next.irq = 1'b1;
    end
    // Hard reset stops output and clears every register
    if (hard_rst)
      r_next = '0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  // Status byte read at generator address 0
  always_comb
  begin
    status = 8'h00;
    status[ST_EL_NEG] = r_reg.el_neg;
    status[ST_EL_POS] = r_reg.el_pos;
    status[ST_ORG] = r_reg.org;
    status[ST_BUSY] = r_reg.running;
    status[ST_IRQ] = r_reg.irq;
  end

  assign step_pulse = r_reg.pulse;
  assign step_dir = ~r_reg.neg;
  assign irq = r_reg.irq;
endmodule
`default_nettype wire

// File: verilog/sbi_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Respond only when upper address byte equals jumper nibble above 1100.
// - Lower byte 0 selects pulse generator; 1 reads counter, writes control.
// - Upper address byte is kept, so a new lower byte alone retargets.
// - Four jumper bits, 0 to 15, form the upper byte's high nibble.
// - Control value a7 gives two-phase, driver off, select 00, lamp on, resets.
// - Low pulse on control bit 1 hard-resets the pulse generator.
// - Board reset resets both chips, driver off, two-phase, select 00.
// - Any counter-address read restarts the watchdog, counter chip or not.
// - Addressed board pulls data line 0 low in a presence read.
// - Interrupt request holds until a generator soft reset command or a generator hard reset.
// - Generator address 0 reads the status byte with interrupt indication.
// - Two control bits drive the board select outputs, codes 00 to 11.
// - A control bit turns the motor driver output on; zero is off.
// - A control bit turns the indicator lamp on; zero is off.
// - Writes at generator address 0 go to its command register.
// - Continuous move runs until stop command, reset, or enabled limit/origin.
// - Direction picks sign; speed selects low or high rate.
// - Origin mode pulses until origin input, same stops as continuous move.
// - With multiplier 732, pulse rate is rate value times 1.000576331967 per second.
module sbi_bus_if
  import sbi_pkg::*;
#(
  parameter int WD_CYCLES = WD_CYC_DEFAULT,
  parameter int RW = RATE_W,
  parameter int MW = MULT_W
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus address cycles
  input wire logic addr_hi_stb,
  input wire logic addr_lo_stb,
  input wire logic [7:0] addr_byte,
  // Bus data cycles
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  input wire logic rd_stb,
  input wire logic presence_read_cycle,
  output logic [7:0] bus_data_out,
  output logic [7:0] bus_data_oe,
  // Board straps
  input wire logic [3:0] jumper_header,
  // Quadrature counter chip
  input wire logic [7:0] qc_rd_data,
  output logic qc_rd_stb,
  output logic qc_reset_n,
  // Driver and board outputs
  output logic drv_enable,
  output logic two_phase,
  output logic [1:0] board_sel,
  output logic indicator_lamp,
  output logic wd_timeout,
  // Motion inputs and setup
  input wire logic limit_neg_n,
  input wire logic limit_pos_n,
  input wire logic origin_n,
  input wire logic [RW-1:0] low_speed_rate,
  input wire logic [RW-1:0] high_speed_rate,
  input wire logic [MW-1:0] rate_multiplier,
  // Motion outputs
  output logic step_pulse,
  output logic step_dir,
  output logic irq
);
  if (WD_CYCLES < 2)
    $error("sbi_bus_if: WD_CYCLES must be at least 2");
  if (RST_PULSE_CYC > 255)
    $error("sbi_bus_if: reset pulse too long for its counter");

  typedef struct packed {
    logic [7:0] hi;
    logic hi_valid;
    logic [7:0] lo;
    logic [7:0] ctrl;
    logic [7:0] pg_rst_cnt;
    logic [7:0] qc_rst_cnt;
    logic pg_hold;
    logic qc_rst_n;
    logic [31:0] wd_cnt;
    logic wd_out;
    logic [7:0] data_out;
    logic [7:0] data_oe;
    logic qc_stb;
  } sbi_bus_t;

  sbi_bus_t r_reg, r_next;
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic match;
  logic pg_sel;
  logic qc_sel;
  logic pg_cmd_stb;
  logic [7:0] pg_status;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Board match and target decode
  always_comb
  begin
    match = r_reg.hi_valid && (r_reg.hi == {jumper_header, ADDR_HI_FIXED});
    pg_sel = match && (r_reg.lo == ADDR_LO_PG);
    qc_sel = match && (r_reg.lo == ADDR_LO_QC);
    pg_cmd_stb = wr_stb && pg_sel;
  end

  // Next state of the bus side
  always_comb
  begin
    r_next = r_reg;
    r_next.data_oe = 8'h00;
    r_next.data_out = 8'h00;
    r_next.qc_stb = 1'b0;
    // Address bytes; the upper one persists across lower-only cycles
    if (addr_hi_stb)
    begin
      r_next.hi = addr_byte;
      r_next.hi_valid = 1'b1;
    end
    if (addr_lo_stb)
      r_next.lo = addr_byte;
    // Reset pulse timers count down to zero
    if (r_reg.pg_rst_cnt != 8'h00)
      r_next.pg_rst_cnt = r_reg.pg_rst_cnt - 8'h01;
    if (r_reg.qc_rst_cnt != 8'h00)
      r_next.qc_rst_cnt = r_reg.qc_rst_cnt - 8'h01;
    // Watchdog runs until it expires, then holds
    if (r_reg.wd_cnt < 32'(WD_CYCLES - 1))
      r_next.wd_cnt = r_reg.wd_cnt + 32'h1;
    else
      r_next.wd_out = 1'b1;
    // Control register write; it has no read path
    if (wr_stb && qc_sel)
    begin
      r_next.ctrl = wr_data;
      if (wr_data[CTL_PG_RST_PULSE])
        r_next.pg_rst_cnt = 8'(RST_PULSE_CYC);
      if (wr_data[CTL_QC_RST_PULSE])
        r_next.qc_rst_cnt = 8'(RST_PULSE_CYC);
    end
    // Register reads: answer is driven for one cycle
    if (rd_stb && pg_sel)
    begin
      r_next.data_out = pg_status;
      r_next.data_oe = 8'hff;
    end
    else if (rd_stb && qc_sel)
    begin
      r_next.data_out = qc_rd_data;
      r_next.data_oe = 8'hff;
      r_next.qc_stb = 1'b1;
      r_next.wd_cnt = 32'h0;
      r_next.wd_out = 1'b0;
    end
    else if (presence_read_cycle && match)
    begin
      r_next.data_out = 8'h00;
      r_next.data_oe = 8'h01;
    end
    // Chip reset levels; generator held while run bit is low
    r_next.pg_hold = !r_next.ctrl[CTL_PG_RUN] || (r_next.pg_rst_cnt != 8'h00);
    r_next.qc_rst_n = (r_next.qc_rst_cnt == 8'h00);
  end

  // Board reset loads driver off, two-phase, select 00, chips in reset
  always_ff @(posedge sys_clk or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      r_reg <= '0;
      r_reg.ctrl <= CTRL_RESET;
      r_reg.pg_hold <= 1'b1;
      r_reg.qc_rst_n <= 1'b0;
      r_reg.qc_rst_cnt <= 8'(RST_PULSE_CYC);
    end
    else
      r_reg <= r_next;
  end

  // Pulse generator
  sbi_pulse_gen #(
    .RW(RW),
    .MW(MW)
  ) u_pulse_gen (
    .clk(sys_clk),
    .rst_n(rst_sync_reg),
    .hard_rst(r_reg.pg_hold),
    .cmd_stb(pg_cmd_stb),
    .cmd_data(wr_data),
    .low_speed_rate(low_speed_rate),
    .high_speed_rate(high_speed_rate),
    .rate_multiplier(rate_multiplier),
    .limit_neg_n(limit_neg_n),
    .limit_pos_n(limit_pos_n),
    .origin_n(origin_n),
    .status(pg_status),
    .step_pulse(step_pulse),
    .step_dir(step_dir),
    .irq(irq)
  );

  // Outputs straight from flops
  assign bus_data_out = r_reg.data_out;
  assign bus_data_oe = r_reg.data_oe;
  assign qc_rd_stb = r_reg.qc_stb;
  assign qc_reset_n = r_reg.qc_rst_n;
  assign drv_enable = r_reg.ctrl[CTL_DRV_EN];
  assign two_phase = r_reg.ctrl[CTL_TWO_PHASE];
  assign board_sel = r_reg.ctrl[CTL_SEL_LO +: 2];
  assign indicator_lamp = r_reg.ctrl[CTL_LED];
  assign wd_timeout = r_reg.wd_out;
endmodule
`default_nettype wire

// File: verif/sbi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host end of the board bus: one strobe per call, released at the taking edge
module sbi_host_model (
  // Clock
  input wire logic sys_clk,
  // Strobes and bytes
  output logic addr_hi_stb,
  output logic addr_lo_stb,
  output logic [7:0] addr_byte,
  output logic wr_stb,
  output logic [7:0] wr_data,
  output logic rd_stb,
  output logic presence_read_cycle,
  // Answer
  input wire logic [7:0] bus_data_out,
  input wire logic [7:0] bus_data_oe
);
  initial {addr_hi_stb, addr_lo_stb, wr_stb, rd_stb, presence_read_cycle, addr_byte, wr_data} = '0;
  // Kind 0 upper, 1 lower, 2 write, 3 read, 4 presence; q is oe then data
  task automatic cyc(input int k, input logic [7:0] b, output logic [15:0] q);
    @(posedge sys_clk);
    addr_hi_stb <= k == 0;
    addr_lo_stb <= k == 1;
    wr_stb <= k == 2;
    rd_stb <= k == 3;
    presence_read_cycle <= k == 4;
    addr_byte <= b;
    wr_data <= b;
    @(posedge sys_clk);
    {addr_hi_stb, addr_lo_stb, wr_stb, rd_stb, presence_read_cycle} <= '0;
    // Released byte lines must not keep looking valid
    addr_byte <= ~b;
    wr_data <= ~b;
    #1 q = {bus_data_oe, bus_data_out};
  endtask
endmodule
`default_nettype wire

// File: verif/sbi_bus_if_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sbi_bus_if_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus
  input wire logic addr_hi_stb,
  input wire logic addr_lo_stb,
  input wire logic [7:0] addr_byte,
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  input wire logic rd_stb,
  input wire logic presence_read_cycle,
  input wire logic [7:0] bus_data_out,
  input wire logic [7:0] bus_data_oe,
  input wire logic [3:0] jumper_header,
  // Board side
  input wire logic [7:0] qc_rd_data,
  input wire logic qc_rd_stb,
  input wire logic qc_reset_n,
  input wire logic drv_enable,
  input wire logic two_phase,
  input wire logic [1:0] board_sel,
  input wire logic indicator_lamp,
  input wire logic wd_timeout,
  input wire logic irq
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] hi_reg;
  logic [7:0] lo_reg;
  // Own address copy, so a strobe never uses the byte sent in its own cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_reg <= 8'h00;
      lo_reg <= 8'h00;
    end
    else
    begin
      if (addr_hi_stb)
        hi_reg <= addr_byte;
      if (addr_lo_stb)
        lo_reg <= addr_byte;
    end
  end
  // A zero upper byte never matches, so no valid flag is needed
  wire logic hit = hi_reg == {jumper_header, 4'hc};
  wire logic qsel = hit && lo_reg == 8'h01;
  AST_OE_CAUSE: assert property (bus_data_oe != 8'h00 |-> $past(rd_stb || presence_read_cycle) && $past(hit))
    else $error("data lines driven without a matched read");
  AST_RD_ANSWER: assert property (rd_stb && hit && lo_reg <= 8'h01 |=> bus_data_oe == 8'hff)
    else $error("matched read not answered");
  AST_PRESENCE: assert property (presence_read_cycle && !rd_stb && hit |=> bus_data_oe == 8'h01 && !bus_data_out[0])
    else $error("presence read not answered low");
  AST_MISS: assert property ((rd_stb || presence_read_cycle) && !hit |=> bus_data_oe == 8'h00)
    else $error("foreign address answered");
  AST_QC_READ: assert property (rd_stb && qsel |=> qc_rd_stb && bus_data_out == $past(qc_rd_data) && !wd_timeout)
    else $error("counter read wrong or watchdog not restarted");
  AST_CTL_WRITE: assert property (wr_stb && qsel |=> {two_phase, drv_enable, indicator_lamp, board_sel} == $past(wr_data[7:3]))
    else $error("control outputs differ from written byte");
  AST_QC_RST: assert property (wr_stb && qsel && wr_data[2] |=> !qc_reset_n [*8])
    else $error("counter reset pulse too short");
  AST_IRQ_HOLD: assert property (irq && !wr_stb && !$past(wr_stb) && !$past(wr_stb, 2) |=> irq)
    else $error("interrupt request dropped without a command");
  AST_RST_STATE: assert property ($rose(rst_n) |-> !drv_enable && two_phase && board_sel == 2'b00 && !qc_reset_n)
    else $error("board reset state wrong");
  cover property (presence_read_cycle && hit);
  cover property (rd_stb && qsel);
  cover property (wr_stb && qsel);
  cover property ($rose(irq));
endmodule
bind sbi_bus_if sbi_bus_if_chk chk_i (.sys_clk, .rst_n, .addr_hi_stb, .addr_lo_stb, .addr_byte, .wr_stb,
  .wr_data, .rd_stb, .presence_read_cycle, .bus_data_out, .bus_data_oe, .jumper_header, .qc_rd_data,
  .qc_rd_stb, .qc_reset_n, .drv_enable, .two_phase, .board_sel, .indicator_lamp, .wd_timeout, .irq);
`default_nettype wire

// File: verif/test_sbi_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
module test_sbi_bus_if;
  import sbi_pkg::*;
  logic sys_clk = 0, rst_n = 0, addr_hi_stb, addr_lo_stb, wr_stb, rd_stb, presence_read_cycle;
  logic [7:0] addr_byte, wr_data, bus_data_out, bus_data_oe, qc_rd_data = 8'h5a;
  logic [3:0] jumper_header = 4'h9;
  logic [1:0] board_sel;
  logic qc_rd_stb, qc_reset_n, drv_enable, two_phase, indicator_lamp, wd_timeout, step_pulse, step_dir, irq;
  logic limit_neg_n = 1, limit_pos_n = 1, origin_n = 1;
  logic [12:0] low_speed_rate = 13'h1fff, high_speed_rate = 13'h1fff;
  logic [15:0] rate_multiplier = 16'hffff, q;
  int err_total = 0, checks = 0, cyc_n = 0;
  // Short watchdog so expiry shows within a few cycles
  sbi_bus_if #(.WD_CYCLES(20)) uut (.sys_clk, .rst_n, .addr_hi_stb, .addr_lo_stb, .addr_byte, .wr_stb,
    .wr_data, .rd_stb, .presence_read_cycle, .bus_data_out, .bus_data_oe, .jumper_header, .qc_rd_data,
    .qc_rd_stb, .qc_reset_n, .drv_enable, .two_phase, .board_sel, .indicator_lamp, .wd_timeout,
    .limit_neg_n, .limit_pos_n, .origin_n, .low_speed_rate, .high_speed_rate, .rate_multiplier,
    .step_pulse, .step_dir, .irq);
  sbi_host_model h (.sys_clk, .addr_hi_stb, .addr_lo_stb, .addr_byte, .wr_stb, .wr_data, .rd_stb,
    .presence_read_cycle, .bus_data_out, .bus_data_oe);
  initial forever #2 sys_clk = ~sys_clk;
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Select a lower byte, then write one byte there
  task automatic put(input logic [7:0] lo, input logic [7:0] v);
    h.cyc(1, lo, q);
    h.cyc(2, v, q);
  endtask
  task automatic wpulse(output int n);
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (step_pulse !== 1'b1 && n < 1000);
  endtask
  task automatic t_ctl;
    chk({drv_enable, two_phase, board_sel, indicator_lamp, qc_reset_n} === 6'b010000, "reset");
    h.cyc(0, 8'h9c, q);
    put(8'h01, 8'ha7);
    chk({two_phase, drv_enable, board_sel, indicator_lamp, qc_reset_n} === 6'b100010, "a7");
    for (int i = 0; i < 4; i++)
    begin
      // Whole byte rebuilt from the bench's own copy, since the register has no read path
      put(8'h01, {1'b0, i[0], i[1], i[1:0], 3'b010});
      chk({drv_enable, indicator_lamp, board_sel, two_phase} === {i[0], i[1], i[1:0], 1'b0}, "ctl");
    end
  endtask
  task automatic t_pres;
    h.cyc(4, 8'h00, q);
    chk(q[15:8] === 8'h01 && q[0] === 1'b0, "presence");
    @(posedge sys_clk);
    jumper_header <= 4'h3;
    h.cyc(4, 8'h00, q);
    chk(q[15:8] === 8'h00, "stale upper byte");
    h.cyc(0, 8'h3d, q);
    h.cyc(4, 8'h00, q);
    chk(q[15:8] === 8'h00, "low nibble");
    h.cyc(0, 8'h3c, q);
    h.cyc(4, 8'h00, q);
    chk(q[15:8] === 8'h01, "new jumpers");
  endtask
  task automatic t_read;
    h.cyc(1, 8'h00, q);
    h.cyc(3, 8'h00, q);
    chk(q[15:8] === 8'hff, "status read");
    repeat (30) @(posedge sys_clk);
    qc_rd_data <= 8'ha5;
    chk(wd_timeout === 1'b1, "watchdog idle");
    h.cyc(1, 8'h01, q);
    h.cyc(3, 8'h00, q);
    chk(q === 16'hffa5 && wd_timeout === 1'b0, "counter read");
    h.cyc(1, 8'h02, q);
    h.cyc(3, 8'h00, q);
    chk(q[15:8] === 8'h00, "lower byte 2");
  endtask
  task automatic t_move;
    longint per;
    int n;
    per = PPS_MOD / (longint'(high_speed_rate) * rate_multiplier);
    put(8'h01, 8'h02);
    put(8'h00, 8'h48);
    put(8'h00, 8'h11);
    h.cyc(3, 8'h00, q);
    chk(q[6] === 1'b1, "not running");
    wpulse(n);
    wpulse(n);
    chk(step_dir === 1'b0 && (n == per || n == per + 1), "step rate");
    put(8'h00, 8'h82);
    h.cyc(3, 8'h00, q);
    chk(q[6] === 1'b0, "decel stop");
    put(8'h00, 8'h11);
    put(8'h01, 8'h00);
    put(8'h01, 8'h02);
    h.cyc(1, 8'h00, q);
    h.cyc(3, 8'h00, q);
    chk(q[6] === 1'b0, "hard reset");
  endtask
  task automatic t_origin;
    put(8'h00, 8'h46);
    put(8'h00, 8'h01);
    @(posedge sys_clk);
    origin_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    origin_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    h.cyc(3, 8'h00, q);
    chk(irq === 1'b1 && step_dir === 1'b1 && q[7:6] === 2'b10, "origin stop");
    put(8'h00, 8'h81);
    chk(irq === 1'b0, "soft reset");
  endtask
  // Cut a hang short
  always @(posedge sys_clk)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      chk(1'b0, "timeout");
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_ctl;
    t_pres;
    t_read;
    t_move;
    t_origin;
    tally_and_finish;
  end
endmodule
`default_nettype wire
